// file: core/image_chunk_pkg.sv
// Summary of operation
// - Active result features append results to frame
// - Results appended only with extended stream enabled
// - Clearing extended enable drops all appending features
// - Extended chunk adds height, width, AOI data
// - Appending works only in video format seven
// - Other formats send plain pixel data unchanged
// - Frame is extended chunk plus feature chunks
// - Payload first, then sixteen byte type identifier
// - Four byte total length follows identifier
// - Last four bytes complement the length
// - Length counts payload, identifier, both length fields
// - Each chunk type has distinct identifier
// - Chunk identifier differs from register identifier
// - Checksum chunk may break general chunk layout
// - Total-bytes inquiry reports enlarged frame size
package image_chunk_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_VFMT     = 8'h04;
  localparam logic [7:0] REG_AOI_POS  = 8'h08;
  localparam logic [7:0] REG_AOI_SIZE = 8'h0c;
  localparam logic [7:0] REG_STRIDE   = 8'h10;
  localparam logic [7:0] REG_PIXFMT   = 8'h14;
  localparam logic [7:0] REG_FCOUNT   = 8'h18;
  localparam logic [7:0] REG_STATUS   = 8'h1c;
  localparam logic [7:0] REG_TOTAL_LO = 8'h20;
  localparam logic [7:0] REG_TOTAL_HI = 8'h24;
  localparam logic [7:0] REG_ID_EXT   = 8'h28;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EXT_BIT  = 0;
  localparam int CTRL_FCNT_BIT = 1;
  localparam logic [2:0]  VFMT_RST    = 3'h0;
  localparam logic [2:0]  VFMT_SCALE  = 3'h7;
  localparam logic [15:0] GEOM_RST    = 16'h0000;
  localparam logic [31:0] STRIDE_RST  = 32'h0000_0000;
  localparam logic [7:0]  DEPTH_RST   = 8'h08;
  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [31:0] WORD_RST    = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Chunk layout: trailer lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [31:0] EXT_META_LEN  = 32'h0000_0018;
  localparam logic [31:0] ID_LEN        = 32'h0000_0010;
  localparam logic [31:0] LENF_LEN      = 32'h0000_0004;
  localparam logic [31:0] EXT_TAIL_LEN  = EXT_META_LEN + ID_LEN
                                          + LENF_LEN + LENF_LEN;
  localparam logic [31:0] FCT_DATA_LEN  = 32'h0000_0004;
  localparam logic [31:0] FCT_CHUNK_LEN = FCT_DATA_LEN + ID_LEN
                                          + LENF_LEN + LENF_LEN;
  localparam logic [5:0]  EXT_LAST_IDX  = 6'h2f;
  localparam logic [5:0]  FCT_LAST_IDX  = 6'h1b;

  // ----------------------------------------------------------------
  // Identifiers; all values arbitrary, each one different
  // ----------------------------------------------------------------
  localparam logic [127:0] EXT_CHUNK_ID =
    128'h0123_4567_89ab_cdef_1111_2222_3333_4444;
  localparam logic [127:0] FCT_CHUNK_ID =
    128'h0123_4567_89ab_cdef_5555_6666_7777_8888;
  localparam logic [31:0]  EXT_CSR_ID   = 32'hfeed_0001;

  // Little-endian byte n of a word
  function automatic logic [7:0] le_byte(input logic [31:0] w,
                                         input logic [1:0]  n);
    le_byte = w[8*n +: 8];
  endfunction : le_byte

endpackage : image_chunk_pkg

// file: core/chunk_tail_mux.sv
`timescale 1ns/100ps
module chunk_tail_mux (
  input  wire logic [5:0]  idx_i,
  input  wire logic        fct_sel_i,
  input  wire logic [31:0] pix_len_i,
  input  wire logic [31:0] stride_i,
  input  wire logic [7:0]  depth_i,
  input  wire logic [15:0] top_i,
  input  wire logic [15:0] left_i,
  input  wire logic [15:0] height_i,
  input  wire logic [15:0] width_i,
  input  wire logic [7:0]  ccode_i,
  input  wire logic [7:0]  cfilt_i,
  input  wire logic [31:0] fcount_i,
  output logic      [7:0]  byte_o
);

  logic [31:0] ext_len;
  logic [31:0] len;
  logic [5:0]  j;

  // Total chunk length includes identifier and both length fields
  assign ext_len = pix_len_i + image_chunk_pkg::EXT_TAIL_LEN;
  assign len = fct_sel_i ? image_chunk_pkg::FCT_CHUNK_LEN : ext_len;

  // Byte select; identifier, then length, then complement close each
  always_comb begin
    byte_o = 8'h00;
    j      = 6'h00;
    if (fct_sel_i) begin
      // Counter payload, then identifier/length/complement
      if (idx_i < 6'h04) begin
        byte_o = image_chunk_pkg::le_byte(fcount_i, idx_i[1:0]);
      end else if (idx_i < 6'h14) begin
        j = 6'h13 - idx_i;
        byte_o = image_chunk_pkg::FCT_CHUNK_ID[8*j[3:0] +: 8];
      end else if (idx_i < 6'h18) begin
        byte_o = image_chunk_pkg::le_byte(len, idx_i[1:0]);
      end else begin
        byte_o = ~image_chunk_pkg::le_byte(len, idx_i[1:0]);
      end
    end else begin
      unique case (idx_i)
        6'h00, 6'h01, 6'h02, 6'h03:
          byte_o = image_chunk_pkg::le_byte(stride_i, idx_i[1:0]);
        6'h07: byte_o = depth_i;
        6'h08: byte_o = top_i[7:0];
        6'h09: byte_o = top_i[15:8];
        6'h0a: byte_o = left_i[7:0];
        6'h0b: byte_o = left_i[15:8];
        6'h0c: byte_o = height_i[7:0];
        6'h0d: byte_o = height_i[15:8];
        6'h0e: byte_o = width_i[7:0];
        6'h0f: byte_o = width_i[15:8];
        6'h13: byte_o = ccode_i;
        6'h17: byte_o = cfilt_i;
        default: begin
          if (idx_i >= 6'h18 && idx_i < 6'h28) begin
            j = 6'h27 - idx_i;
            byte_o = image_chunk_pkg::EXT_CHUNK_ID[8*j[3:0] +: 8];
          end else if (idx_i >= 6'h28 && idx_i < 6'h2c) begin
            byte_o = image_chunk_pkg::le_byte(len, idx_i[1:0]);
          end else if (idx_i >= 6'h2c) begin
            byte_o = ~image_chunk_pkg::le_byte(len, idx_i[1:0]);
          end else begin
            byte_o = 8'h00; // Reserved bytes
          end
        end
      endcase
    end
  end

endmodule : chunk_tail_mux

// file: core/image_chunk_appender.sv
`timescale 1ns/100ps
module image_chunk_appender (
  input  wire logic        clock_i,
  input  wire logic        reset_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Pixel byte stream from capture logic
  input  wire logic        pix_valid_i,
  input  wire logic [7:0]  pix_data_i,
  input  wire logic        pix_sof_i,
  input  wire logic        pix_eof_i,
  output logic             busy_o,
  // Frame byte stream towards the link
  output logic             out_valid_o,
  output logic [7:0]       out_data_o,
  output logic             out_sof_o,
  output logic             out_eof_o
);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  // Framer states, Gray coded
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PIX  = 2'b01,
    ST_EXT  = 2'b11,
    ST_FCT  = 2'b10
  } fsm_t;

  // Whole module state
  typedef struct packed {
    // Framer
    fsm_t        st;
    logic [31:0] k;
    logic [5:0]  idx;
    logic        app;
    logic        fct;
    logic [31:0] fsnap;
    logic [31:0] fcnt;

    // Settings
    logic        ext_en;
    logic        fcnt_en;
    logic [2:0]  vfmt;
    logic [15:0] top;
    logic [15:0] left;
    logic [15:0] height;
    logic [15:0] width;
    logic [31:0] stride;
    logic [7:0]  depth;
    logic [7:0]  ccode;
    logic [7:0]  cfilt;

    // Bus reply
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;

    // Stream
    logic        ov;
    logic [7:0]  od;
    logic        osof;
    logic        oeof;
    logic        busy;
  } regs_t;

  // Registered state and next value
  regs_t       r_ff;
  regs_t       nxt_r;

  // Helpers
  logic [7:0]  tail_byte;
  logic        fmt_ok;
  logic        ext_live;
  logic        fct_live;
  logic [31:0] pix_bytes;
  logic [31:0] total_bytes;

  // Bus strobes
  logic        apb_done;
  logic        wr_done;

  // ----------------------------------------------------------------
  // Trailer byte generator
  // ----------------------------------------------------------------
  // Trailer byte at current index
  chunk_tail_mux u_tail (
    .idx_i     (r_ff.idx),
    .fct_sel_i (r_ff.st == ST_FCT),
    .pix_len_i (r_ff.k),
    .stride_i  (r_ff.stride),
    .depth_i   (r_ff.depth),
    .top_i     (r_ff.top),
    .left_i    (r_ff.left),
    .height_i  (r_ff.height),
    .width_i   (r_ff.width),
    .ccode_i   (r_ff.ccode),
    .cfilt_i   (r_ff.cfilt),
    .fcount_i  (r_ff.fsnap),
    .byte_o    (tail_byte)
  );

  // ----------------------------------------------------------------
  // Effective feature state
  // ----------------------------------------------------------------
  // Appending only in the scalable format and behind the stream enable
  assign fmt_ok   = (r_ff.vfmt == image_chunk_pkg::VFMT_SCALE);
  assign ext_live = r_ff.ext_en && fmt_ok;
  assign fct_live = ext_live && r_ff.fcnt_en;

  // Predicted frame size for the size inquiry
  assign pix_bytes   = r_ff.stride[15:0] * r_ff.height;
  assign total_bytes = pix_bytes
    + (ext_live ? image_chunk_pkg::EXT_TAIL_LEN : 32'h0)
    + (fct_live ? image_chunk_pkg::FCT_CHUNK_LEN : 32'h0);

  // Transfer completes at the edge where pready is seen high
  assign apb_done = psel_i && penable_i && r_ff.pready;
  assign wr_done  = apb_done && pwrite_i && !r_ff.pslverr;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    nxt_r = r_ff;

    // APB: one wait state, then answer for one cycle
    nxt_r.pready  = 1'b0;
    nxt_r.pslverr = 1'b0;
    if (psel_i && penable_i && !r_ff.pready) begin
      nxt_r.pready = 1'b1;
      nxt_r.prdata = 32'h0;
      // Read mux; unmapped gives error
      unique case (paddr_i)
        // Enables
        image_chunk_pkg::REG_CTRL: begin
          nxt_r.prdata[image_chunk_pkg::CTRL_EXT_BIT]  = r_ff.ext_en;
          nxt_r.prdata[image_chunk_pkg::CTRL_FCNT_BIT] = r_ff.fcnt_en;
        end
        image_chunk_pkg::REG_VFMT:
          nxt_r.prdata = {29'h0, r_ff.vfmt};
        image_chunk_pkg::REG_AOI_POS:
          nxt_r.prdata = {r_ff.left, r_ff.top};
        image_chunk_pkg::REG_AOI_SIZE:
          nxt_r.prdata = {r_ff.width, r_ff.height};
        image_chunk_pkg::REG_STRIDE:
          nxt_r.prdata = r_ff.stride;
        image_chunk_pkg::REG_PIXFMT:
          nxt_r.prdata = {8'h0, r_ff.cfilt, r_ff.ccode, r_ff.depth};
        image_chunk_pkg::REG_FCOUNT:
          nxt_r.prdata = r_ff.fcnt;
        // Live status
        image_chunk_pkg::REG_STATUS:
          nxt_r.prdata = {27'h0, fct_live, ext_live, r_ff.busy, r_ff.st};
        // Size with chunks
        image_chunk_pkg::REG_TOTAL_LO:
          nxt_r.prdata = total_bytes;
        image_chunk_pkg::REG_TOTAL_HI:
          nxt_r.prdata = 32'h0;
        // Feature id
        image_chunk_pkg::REG_ID_EXT:
          nxt_r.prdata = image_chunk_pkg::EXT_CSR_ID;
        default:
          nxt_r.pslverr = 1'b1;
      endcase
      // Writes read back zero
      if (pwrite_i) begin
        nxt_r.prdata = 32'h0;
      end
    end

    // Register writes
    if (wr_done) begin
      unique case (paddr_i)
        image_chunk_pkg::REG_CTRL: begin
          nxt_r.ext_en  = pwdata_i[image_chunk_pkg::CTRL_EXT_BIT];
          // Dropping the stream enable switches off every appender
          nxt_r.fcnt_en = pwdata_i[image_chunk_pkg::CTRL_FCNT_BIT]
                          && pwdata_i[image_chunk_pkg::CTRL_EXT_BIT];
        end
        image_chunk_pkg::REG_VFMT:
          nxt_r.vfmt = pwdata_i[2:0];
        // Geometry used live
        image_chunk_pkg::REG_AOI_POS: begin
          nxt_r.top  = pwdata_i[15:0];
          nxt_r.left = pwdata_i[31:16];
        end
        image_chunk_pkg::REG_AOI_SIZE: begin
          nxt_r.height = pwdata_i[15:0];
          nxt_r.width  = pwdata_i[31:16];
        end
        // Row pitch
        image_chunk_pkg::REG_STRIDE:
          nxt_r.stride = pwdata_i;
        // Bytes for the trailer
        image_chunk_pkg::REG_PIXFMT: begin
          nxt_r.depth = pwdata_i[7:0];
          nxt_r.ccode = pwdata_i[15:8];
          nxt_r.cfilt = pwdata_i[23:16];
        end
        default: ;
      endcase
    end

    // Output stream defaults to idle each cycle
    nxt_r.ov   = 1'b0;
    nxt_r.osof = 1'b0;
    nxt_r.oeof = 1'b0;

    // Framer
    unique case (r_ff.st)
      ST_IDLE: begin
        // Wait for frame start
        if (pix_valid_i && pix_sof_i) begin
          // Features are frozen for the whole frame
          nxt_r.app   = ext_live;
          nxt_r.fct   = fct_live;
          nxt_r.fsnap = r_ff.fcnt;
          nxt_r.fcnt  = r_ff.fcnt + 32'h1;
          nxt_r.k     = 32'h1;
          nxt_r.ov    = 1'b1;
          nxt_r.od    = pix_data_i;
          nxt_r.osof  = 1'b1;
          nxt_r.idx   = 6'h00;
          if (pix_eof_i) begin
            // One-byte frame
            nxt_r.oeof = !ext_live;
            nxt_r.st   = ext_live ? ST_EXT : ST_IDLE;
          end else begin
            nxt_r.st = ST_PIX;
          end
        end
      end

      ST_PIX: begin
        // Pass bytes until eof
        if (pix_valid_i) begin
          nxt_r.k  = r_ff.k + 32'h1;
          nxt_r.ov = 1'b1;
          nxt_r.od = pix_data_i;
          if (pix_eof_i) begin
            nxt_r.oeof = !r_ff.app;
            nxt_r.st   = r_ff.app ? ST_EXT : ST_IDLE;
          end
        end
      end

      ST_EXT: begin
        // Extended chunk trailer: metadata, identifier, lengths
        nxt_r.ov  = 1'b1;
        nxt_r.od  = tail_byte;
        nxt_r.idx = r_ff.idx + 6'h01;
        // Last byte ends frame or chunk
        if (r_ff.idx == image_chunk_pkg::EXT_LAST_IDX) begin
          nxt_r.idx  = 6'h00;
          nxt_r.oeof = !r_ff.fct;
          nxt_r.st   = r_ff.fct ? ST_FCT : ST_IDLE;
        end
      end

      ST_FCT: begin
        // Result chunk; no checksum chunk is produced here
        nxt_r.ov  = 1'b1;
        nxt_r.od  = tail_byte;
        nxt_r.idx = r_ff.idx + 6'h01;
        // Last byte ends the frame
        if (r_ff.idx == image_chunk_pkg::FCT_LAST_IDX) begin
          nxt_r.idx  = 6'h00;
          nxt_r.oeof = 1'b1;
          nxt_r.st   = ST_IDLE;
        end
      end
    endcase

    // Source must hold off while trailers are sent
    nxt_r.busy = (nxt_r.st == ST_EXT) || (nxt_r.st == ST_FCT);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      // Framer
      r_ff.st      <= ST_IDLE;
      r_ff.k       <= image_chunk_pkg::WORD_RST;
      r_ff.idx     <= 6'h00;
      r_ff.app     <= 1'b0;
      r_ff.fct     <= 1'b0;
      r_ff.fsnap   <= image_chunk_pkg::WORD_RST;
      r_ff.fcnt    <= image_chunk_pkg::WORD_RST;

      // Settings
      r_ff.ext_en  <= 1'b0;
      r_ff.fcnt_en <= 1'b0;
      r_ff.vfmt    <= image_chunk_pkg::VFMT_RST;
      r_ff.top     <= image_chunk_pkg::GEOM_RST;
      r_ff.left    <= image_chunk_pkg::GEOM_RST;
      r_ff.height  <= image_chunk_pkg::GEOM_RST;
      r_ff.width   <= image_chunk_pkg::GEOM_RST;
      r_ff.stride  <= image_chunk_pkg::STRIDE_RST;
      r_ff.depth   <= image_chunk_pkg::DEPTH_RST;
      r_ff.ccode   <= image_chunk_pkg::BYTE_RST;
      r_ff.cfilt   <= image_chunk_pkg::BYTE_RST;

      // Bus reply
      r_ff.prdata  <= image_chunk_pkg::WORD_RST;
      r_ff.pready  <= 1'b0;
      r_ff.pslverr <= 1'b0;

      // Stream
      r_ff.ov      <= 1'b0;
      r_ff.od      <= image_chunk_pkg::BYTE_RST;
      r_ff.osof    <= 1'b0;
      r_ff.oeof    <= 1'b0;
      r_ff.busy    <= 1'b0;
    end else begin
      // Take the whole next state
      r_ff <= nxt_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  // Bus reply
  assign prdata_o    = r_ff.prdata;
  assign pready_o    = r_ff.pready;
  assign pslverr_o   = r_ff.pslverr;

  // Stream
  assign out_valid_o = r_ff.ov;
  assign out_data_o  = r_ff.od;
  assign out_sof_o   = r_ff.osof;
  assign out_eof_o   = r_ff.oeof;
  assign busy_o      = r_ff.busy;

endmodule : image_chunk_appender

// file: sim/image_chunk_appender_assertions.sv
`timescale 1ns/100ps
module image_chunk_appender_assertions (
  input wire logic        clock_i,
  input wire logic        reset_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        pix_valid_i,
  input wire logic [7:0]  pix_data_i,
  input wire logic        pix_sof_i,
  input wire logic        busy_o,
  input wire logic        out_valid_o,
  input wire logic [7:0]  out_data_o,
  input wire logic        out_sof_o,
  input wire logic        out_eof_o
);
  logic [55:0] hist_ff;
  logic [31:0] len_w;
  logic [31:0] inv_w;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // Last seven output bytes, newest in the low byte
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) hist_ff <= 56'h0;
    else if (out_valid_o) hist_ff <= {hist_ff[47:0], out_data_o};
  end
  // Length and inverted length of the chunk ending now
  assign len_w = {hist_ff[31:24], hist_ff[39:32], hist_ff[47:40],
                  hist_ff[55:48]};
  assign inv_w = {out_data_o, hist_ff[7:0], hist_ff[15:8], hist_ff[23:16]};
  sequence s_access;
    psel_i && penable_i && !pready_o;
  endsequence
  sequence s_reply;
    pready_o ##1 !pready_o;
  endsequence
  sequence s_trail_go;
    $rose(busy_o);
  endsequence
  sequence s_trail_end;
    out_eof_o && !busy_o;
  endsequence
  AST_APB_ONE_WAIT: assert property (s_access |=> s_reply)
    else $error("pready not one cycle into access");
  AST_ERR_WITH_READY: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  AST_WR_DATA_ZERO: assert property (pready_o && pwrite_i |-> prdata_o == 0)
    else $error("read data not zero on write");
  AST_SOF_PASS: assert property (pix_valid_i && pix_sof_i && !busy_o
    |=> out_valid_o && out_data_o == $past(pix_data_i))
    else $error("first pixel byte not passed on");
  AST_FLAGS_VALID: assert property (out_sof_o || out_eof_o |-> out_valid_o)
    else $error("frame flag without valid byte");
  AST_BUSY_STREAMS: assert property (busy_o |=> out_valid_o && !out_sof_o)
    else $error("gap or restart inside trailer");
  AST_TRAILER_END: assert property (s_trail_go |-> ##[48:76] s_trail_end)
    else $error("trailer length out of range");
  AST_LEN_COMPLEMENT: assert property (out_eof_o && $past(busy_o)
    |-> inv_w == ~len_w)
    else $error("inverted length wrong");
endmodule : image_chunk_appender_assertions

bind image_chunk_appender image_chunk_appender_assertions u_chk (
  .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pix_valid_i(pix_valid_i),
  .pix_data_i(pix_data_i), .pix_sof_i(pix_sof_i), .busy_o(busy_o),
  .out_valid_o(out_valid_o), .out_data_o(out_data_o),
  .out_sof_o(out_sof_o), .out_eof_o(out_eof_o));

// file: sim/frame_host_model.sv
`timescale 1ns/100ps
module frame_host_model (
  input  wire logic       clock_i,
  input  wire logic       reset_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       eof_i,
  output logic            done_o,
  output logic [3:0]      chunks_o,
  output logic            bad_o
);
  logic [7:0] buf_q[$];
  // Gather a frame, then walk its chunks back from the tail
  always @(posedge clock_i or posedge reset_i) begin
    int pos;
    logic [31:0] len;
    logic [31:0] inv;
    int cnt;
    done_o <= !reset_i && valid_i && eof_i;
    if (reset_i) begin
      buf_q = {};
      chunks_o <= 4'h0;
      bad_o <= 1'b0;
    end else if (valid_i) begin
      buf_q.push_back(data_i);
      if (eof_i) begin
        pos = buf_q.size();
        cnt = 0;
        while (pos >= 24) begin
          len = {buf_q[pos-5], buf_q[pos-6], buf_q[pos-7], buf_q[pos-8]};
          inv = {buf_q[pos-1], buf_q[pos-2], buf_q[pos-3], buf_q[pos-4]};
          if (inv !== ~len || len > pos || len < 24) break;
          pos = pos - len;
          cnt++;
        end
        chunks_o <= 4'(cnt);
        bad_o <= (pos != 0);
        buf_q = {};
      end
    end
  end
endmodule : frame_host_model

// file: sim/image_chunk_appender_tb_top.sv
`timescale 1ns/100ps
module image_chunk_appender_tb_top;
  logic        clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, busy_o;
  logic        pix_valid_i = 1'b0;
  logic [7:0]  pix_data_i = 8'h00;
  logic        pix_sof_i = 1'b0;
  logic        pix_eof_i = 1'b0;
  logic        out_valid_o, out_sof_o, out_eof_o, done, bad;
  logic [7:0]  out_data_o;
  logic [3:0]  chunks;
  int          n_errors = 0;
  int          check_count = 0;
  int          frames = 0;
  logic [32:0] apb_q[$];
  logic [10:0] pix_q[$];
  logic [4:0]  frm_q[$];
  logic [31:0] stride;
  logic [15:0] top, left, hgt, wid;
  logic [7:0]  depth, ccode, cfilt;

  always #50 clock_i = ~clock_i;

  image_chunk_appender dut (.clock_i(clock_i), .reset_i(reset_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pix_valid_i(pix_valid_i),
    .pix_data_i(pix_data_i), .pix_sof_i(pix_sof_i), .pix_eof_i(pix_eof_i),
    .busy_o(busy_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_sof_o(out_sof_o), .out_eof_o(out_eof_o));
  frame_host_model host (.clock_i(clock_i), .reset_i(reset_i),
    .valid_i(out_valid_o), .data_i(out_data_o), .eof_i(out_eof_o),
    .done_o(done), .chunks_o(chunks), .bad_o(bad));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [32:0] seen,
                       input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("Checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // Oldest note is compared against each reply, byte and frame
  always @(posedge clock_i) begin
    logic [10:0] e;
    if (!reset_i && pready_o !== 1'b0)
      check("apb", {pslverr_o, prdata_o}, apb_q.size() ? apb_q.pop_front() : 'x);
    if (!reset_i && out_valid_o !== 1'b0) begin
      e = pix_q.size() ? pix_q.pop_front() : 'x;
      check("byte", {e[10], out_sof_o, out_eof_o,
        e[10] ? e[7:0] : out_data_o}, e);
    end
    if (!reset_i && done !== 1'b0)
      check("host", {bad, chunks}, frm_q.size() ? frm_q.pop_front() : 'x);
  end

  // Hang guard
  initial begin
    #(100 * 20000);
    n_errors++;
    conclude();
  end

  // ------------------------------------------------------------
  // Bus and stream drivers
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [32:0] exp);
    apb_q.push_back(exp);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    do @(posedge clock_i); while (pready_o !== 1'b1);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, {1'b0, exp});
  endtask : rd

  function automatic logic [31:0] le32(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : le32

  task automatic frame(input int k, input logic ext, input logic fct);
    logic [7:0]   d;
    logic [31:0]  len;
    logic [383:0] et;
    logic [223:0] ft;
    len = 32'(k) + 32'h0000_0030;
    et = {le32(stride), 24'h0, depth, top[7:0], top[15:8], left[7:0],
          left[15:8], hgt[7:0], hgt[15:8], wid[7:0], wid[15:8], 24'h0,
          ccode, 24'h0, cfilt, image_chunk_pkg::EXT_CHUNK_ID,
          le32(len), le32(~len)};
    ft = {le32(32'(frames)), image_chunk_pkg::FCT_CHUNK_ID,
          le32(32'h0000_001c), le32(~32'h0000_001c)};
    frames++;
    for (int i = 0; i < k; i++) begin
      d = 8'($urandom);
      pix_q.push_back({1'b0, i == 0, i == k - 1 && !ext, d});
      pix_valid_i <= 1'b1;
      pix_sof_i <= (i == 0);
      pix_eof_i <= (i == k - 1);
      pix_data_i <= d;
      @(posedge clock_i);
    end
    for (int i = 0; i < 48 && ext; i++)
      pix_q.push_back({1'b0, 1'b0, i == 47 && !fct, et[383-8*i -: 8]});
    for (int i = 0; i < 28 && fct; i++)
      pix_q.push_back({1'b0, 1'b0, i == 27, ft[223-8*i -: 8]});
    frm_q.push_back({!ext, 4'(ext) + 4'(fct)});
    pix_valid_i <= 1'b0;
    pix_sof_i <= 1'b0;
    pix_eof_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    for (int n = 0; n < 100 && busy_o !== 1'b0; n++) @(posedge clock_i);
    check("busy", busy_o, 1'b0);
    repeat (2) @(posedge clock_i);
  endtask : frame

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h5b6c8bee));
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    // Reset values, unmapped place and read-only total
    rd(image_chunk_pkg::REG_CTRL, 32'h0);
    rd(image_chunk_pkg::REG_VFMT, 32'h0);
    rd(image_chunk_pkg::REG_PIXFMT, 32'h0000_0008);
    rd(image_chunk_pkg::REG_TOTAL_HI, 32'h0);
    apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
    apb(1'b1, 8'h44, 32'h1, {1'b1, 32'h0});
    $display("Test registers done");
    {stride, top, left, hgt, wid} = {$urandom, $urandom, $urandom};
    {depth, ccode, cfilt} = 24'($urandom);
    wr(image_chunk_pkg::REG_AOI_POS, {left, top});
    wr(image_chunk_pkg::REG_AOI_SIZE, {wid, hgt});
    wr(image_chunk_pkg::REG_STRIDE, stride);
    wr(image_chunk_pkg::REG_PIXFMT, {8'h0, cfilt, ccode, depth});
    // Enables set but not in format seven: plain frame only
    wr(image_chunk_pkg::REG_CTRL, 32'h3);
    frame(1 + $urandom % 20, 1'b0, 1'b0);
    $display("Test plain format done");
    wr(image_chunk_pkg::REG_VFMT, 32'h7);
    wr(image_chunk_pkg::REG_CTRL, 32'h1);
    rd(image_chunk_pkg::REG_TOTAL_LO, 32'(stride[15:0] * hgt + 32'h30));
    frame(1 + $urandom % 40, 1'b1, 1'b0);
    $display("Test extended chunk done");
    wr(image_chunk_pkg::REG_CTRL, 32'h3);
    rd(image_chunk_pkg::REG_TOTAL_LO, 32'(stride[15:0] * hgt + 32'h4c));
    frame(1, 1'b1, 1'b1);
    frame(1 + $urandom % 40, 1'b1, 1'b1);
    wr(image_chunk_pkg::REG_FCOUNT, 32'hffff_0000);
    rd(image_chunk_pkg::REG_FCOUNT, 32'(frames));
    $display("Test counter chunk done");
    // Counter enable without extended stream appends nothing
    wr(image_chunk_pkg::REG_CTRL, 32'h2);
    rd(image_chunk_pkg::REG_CTRL, 32'h0);
    frame(1 + $urandom % 20, 1'b0, 1'b0);
    $display("Test disable done");
    check("queues", apb_q.size() + pix_q.size() + frm_q.size(), 0);
    conclude();
  end
endmodule : image_chunk_appender_tb_top
